// ### rtl/io_ctrl_config_status_regs.v
// Summary of operation
// - hardware only clears master enable, at reset and on bus timeout
// - wide entry mode bit is one at reset when wide capable
// - clearing wide mode selects narrow entries; address register stays two words
// - narrow-only build ignores stores to the wide mode bit
// - bits 25-27 report maximum table size, read-only
// - bits 28-31 report slave channel count, read-only
// - exactly fifteen arbitration levels regardless of channel count
// - at least two slave channels are provided
// - configuration resets to zero apart from wide bit, table size and channel count
// - personalization unimplemented bits ignore stores and read zero
// - snapshot latches arbitration, burst, ready and status lines on timeout
// - arbitration line 0 is snapshot lsb, line 3 the arbitration field msb
// - after i/o cycle timeout, later errors not trapped until clear
// - snapshot ignores stores, reads valid when error flag set, upper zero
`timescale 1ns/1ps
`default_nettype none
`include "io_ctrl_map.vh"
module io_ctrl_config_status_regs #(
  parameter WIDE_CAPABLE = 1,
  parameter [2:0] TABLE_MAX = 3'h7,
  parameter [3:0] DMA_CHANNELS = 4'h8,
  parameter [31:0] PERS_MASK = 32'h0000_00FF
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [1:0] reg_sel_i,
  input wire load_i,
  input wire store_i,
  input wire [31:0] wdata_i,
  output reg [31:0] rdata_o,
  output reg rvalid_o,
  input wire bus_timeout_i,
  input wire io_cycle_i,
  input wire err_clear_i,
  input wire [3:0] arb_pin_i,
  input wire burst_pin_i,
  input wire card_channel_ready_pin_i,
  input wire sdr0_pin_i,
  input wire sdr1_pin_i,
  input wire ext_irq_i,
  input wire arb_req_i,
  input wire [3:0] arb_level_i,
  output reg master_enable_o,
  output reg wide_entry_mode_o,
  output reg addr_two_words_o,
  output reg irq_to_system_o,
  output reg arb_start_o,
  output reg [3:0] arb_level_o,
  output reg err_flag_o,
  output reg [3:0] dma_channels_o,
  output reg [31:0] pers_o
);

  // channel count held between the floor and the field maximum
  localparam [3:0] DMA_EFF =
    (DMA_CHANNELS < `DMA_MIN) ? `DMA_MIN : DMA_CHANNELS;
  localparam [31:0] ARB_TOP_W = `ARB_LEVELS - 1;
  localparam [3:0] ARB_TOP = ARB_TOP_W[3:0];
  localparam [31:0] PERS_RST_W = `PERS_RST;
  localparam WIDE_ON = (WIDE_CAPABLE != 0);

  // configuration state
  reg master_enable;
  reg wide_mode;
  wire [31:0] pers;
  reg [31:0] next_rdata;

  // synchronised bus lines and snapshot results
  wire [`SNAP_W-1:0] bus_lines;
  wire [`SNAP_W-1:0] snap;
  wire err_flag;
  wire locked;
  wire [`SNAP_W-1:0] raw_lines;

  // store strobes per register
  wire cfg_store;
  wire pers_store;
  wire level_ok;
  wire sel_cfg;
  wire sel_pers;

  // read words assembled field by field
  wire [31:0] cfg_word;
  wire [31:0] pers_word;
  wire [31:0] snap_word;

  // pack raw pins; arbitration line 0 lands at the lsb
  assign raw_lines[`SNAP_ARB_HI:`SNAP_ARB_LO] = arb_pin_i;
  assign raw_lines[`SNAP_BURST_BIT] = burst_pin_i;
  assign raw_lines[`SNAP_RDY_BIT] = card_channel_ready_pin_i;
  assign raw_lines[`SNAP_SDR0_BIT] = sdr0_pin_i;
  assign raw_lines[`SNAP_SDR1_BIT] = sdr1_pin_i;

  // bus lines come from another domain
  pin_sync3 #(
    .W(`SNAP_W)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pin_i(raw_lines),
    .level_o(bus_lines)
  );

  // error capture, held from an i/o cycle timeout until clear, and error flag
  fault_snapshot u_snap (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .timeout_i(bus_timeout_i),
    .io_cycle_i(io_cycle_i),
    .err_clear_i(err_clear_i),
    .lines_i(bus_lines),
    .snap_o(snap),
    .err_flag_o(err_flag),
    .locked_o(locked)
  );

  // decode stores; snapshot has no store path
  assign sel_cfg = (reg_sel_i == `CFG_SEL);
  assign sel_pers = (reg_sel_i == `PERS_SEL);
  assign cfg_store = store_i && sel_cfg;
  assign pers_store = store_i && sel_pers;

  // only levels 0 to 14 are device levels
  assign level_ok = (arb_level_i <= ARB_TOP);

  // configuration word; reserved bits tie to zero
  assign cfg_word[`CFG_ME_BIT] = master_enable;
  assign cfg_word[`CFG_ME_BIT-1:`CFG_WIDE_BIT+1] = 23'h00_0000;
  assign cfg_word[`CFG_WIDE_BIT] = wide_mode;
  assign cfg_word[`CFG_TMAX_HI:`CFG_TMAX_LO] = TABLE_MAX;
  assign cfg_word[`CFG_DMA_HI:`CFG_DMA_LO] = DMA_EFF;

  // personalization word; unimplemented bits read zero
  assign pers_word = pers & PERS_MASK;

  // snapshot word; the capture shows only while the error stands
  assign snap_word[31:`SNAP_W] = 24'h00_0000;
  assign snap_word[`SNAP_W-1:0] = err_flag ? snap : `SNAP_RST;

  // master enable: timeout clear beats a store in the same cycle
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      master_enable <= `ME_RST;
    end else if (bus_timeout_i) begin
      master_enable <= 1'b0;
    end else if (cfg_store) begin
      master_enable <= wdata_i[`CFG_ME_BIT];
    end
  end

  // wide entry mode: set at reset when capable, writable only then
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      wide_mode <= WIDE_ON;
    end else if (cfg_store && WIDE_ON) begin
      wide_mode <= wdata_i[`CFG_WIDE_BIT];
    end else begin
      wide_mode <= wide_mode & WIDE_ON;
    end
  end

  // personalization: only implemented positions get a flop
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : pers_bit
      if (PERS_MASK[g]) begin : impl
        reg bit_q;
        always @(posedge ref_clk_i) begin
          if (rst_i) begin
            bit_q <= PERS_RST_W[g];
          end else if (pers_store) begin
            bit_q <= wdata_i[g];
          end
        end
        assign pers[g] = bit_q;
      end else begin : unimpl
        assign pers[g] = 1'b0;
      end
    end
  endgenerate

  // load data mux; the unmapped select reads zero
  always @* begin
    next_rdata = 32'h0000_0000;
    case (reg_sel_i)
      `CFG_SEL: begin
        next_rdata = cfg_word;
      end
      `PERS_SEL: begin
        next_rdata = pers_word;
      end
      `SNAP_SEL: begin
        next_rdata = snap_word;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // load valid pulses the edge after the strobe
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= load_i;
    end
  end

  // load data holds until the next load
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (load_i) begin
      rdata_o <= next_rdata;
    end
  end

  // interrupts pass only while enabled and with no timeout this cycle
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_to_system_o <= 1'b0;
    end else begin
      irq_to_system_o <= ext_irq_i && master_enable && !bus_timeout_i;
    end
  end

  // arbitration starts only on a device level while enabled
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      arb_start_o <= 1'b0;
    end else begin
      arb_start_o <= arb_req_i && level_ok && master_enable && !bus_timeout_i;
    end
  end

  // last accepted device level
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      arb_level_o <= 4'h0;
    end else if (arb_req_i && level_ok) begin
      arb_level_o <= arb_level_i;
    end
  end

  // enable as seen outside; a timeout this cycle already reads low
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      master_enable_o <= `ME_RST;
    end else begin
      master_enable_o <= master_enable && !bus_timeout_i;
    end
  end

  // entry size in use
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      wide_entry_mode_o <= 1'b0;
    end else begin
      wide_entry_mode_o <= wide_mode;
    end
  end

  // address register stays two words whenever the build is wide capable
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      addr_two_words_o <= 1'b0;
    end else begin
      addr_two_words_o <= WIDE_ON;
    end
  end

  // flag shows its next value, so a set and a clear both appear at once
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      err_flag_o <= 1'b0;
    end else begin
      err_flag_o <= bus_timeout_i || (err_flag && !err_clear_i);
    end
  end

  // fixed channel count
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      dma_channels_o <= 4'h0;
    end else begin
      dma_channels_o <= DMA_EFF;
    end
  end

  // personalization copy
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      pers_o <= 32'h0000_0000;
    end else begin
      pers_o <= pers;
    end
  end

endmodule
`default_nettype wire

// ### rtl/io_ctrl_map.vh
`ifndef IO_CTRL_MAP_VH
`define IO_CTRL_MAP_VH

// register select codes on the load/store port
`define CFG_SEL 2'h0
`define PERS_SEL 2'h1
`define SNAP_SEL 2'h2

// configuration register fields, vector bit = 31 - printed bit
`define CFG_ME_BIT 31
`define CFG_WIDE_BIT 7
`define CFG_TMAX_HI 6
`define CFG_TMAX_LO 4
`define CFG_DMA_HI 3
`define CFG_DMA_LO 0

// snapshot register fields
`define SNAP_ARB_HI 3
`define SNAP_ARB_LO 0
`define SNAP_BURST_BIT 4
`define SNAP_RDY_BIT 5
`define SNAP_SDR0_BIT 6
`define SNAP_SDR1_BIT 7
`define SNAP_W 8

// reset values
`define ME_RST 1'h0
`define PERS_RST 32'h0000_0000
`define SNAP_RST 8'h00

// arbitration levels and channel limits
`define ARB_LEVELS 15
`define ARB_IDLE 4'hF
`define DMA_MIN 4'h2
`define DMA_MAX 4'hF

`endif

// ### rtl/pin_sync3.v
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter W = 8
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [W-1:0] pin_i,
  output reg [W-1:0] level_o
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  genvar g;
  // three-flop chain plus an output flop per line; a change counts once the last two chain flops agree
  generate
    for (g = 0; g < W; g = g + 1) begin : bit_sync
      always @(posedge ref_clk_i) begin
        if (rst_i) begin
          s1[g] <= 1'b0;
          s2[g] <= 1'b0;
          s3[g] <= 1'b0;
          level_o[g] <= 1'b0;
        end else begin
          s1[g] <= pin_i[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            level_o[g] <= s3[g];
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### rtl/fault_snapshot.v
`timescale 1ns/1ps
`default_nettype none
`include "io_ctrl_map.vh"
module fault_snapshot (
  input wire ref_clk_i,
  input wire rst_i,
  input wire timeout_i,
  input wire io_cycle_i,
  input wire err_clear_i,
  input wire [`SNAP_W-1:0] lines_i,
  output reg [`SNAP_W-1:0] snap_o,
  output reg err_flag_o,
  output reg locked_o
);
  // capture while unlocked; an i/o cycle timeout locks until clear
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      snap_o <= `SNAP_RST;
      err_flag_o <= 1'b0;
      locked_o <= 1'b0;
    end else begin
      if (timeout_i && !locked_o) begin
        snap_o <= lines_i;
      end
      // set wins over a clear in the same cycle
      if (timeout_i) begin
        err_flag_o <= 1'b1;
      end else if (err_clear_i) begin
        err_flag_o <= 1'b0;
      end
      if (timeout_i && io_cycle_i) begin
        locked_o <= 1'b1;
      end else if (err_clear_i) begin
        locked_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/io_ctrl_config_status_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module io_ctrl_sva #(
  parameter WIDE_CAPABLE = 1,
  parameter [2:0] TABLE_MAX = 3'h7,
  parameter [3:0] DMA_CHANNELS = 4'h8,
  parameter [31:0] PERS_MASK = 32'h0000_00FF
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire [1:0] reg_sel_i,
  input wire load_i,
  input wire store_i,
  input wire [31:0] wdata_i,
  input wire [31:0] rdata_o,
  input wire rvalid_o,
  input wire bus_timeout_i,
  input wire io_cycle_i,
  input wire err_clear_i,
  input wire ext_irq_i,
  input wire arb_req_i,
  input wire [3:0] arb_level_i,
  input wire master_enable_o,
  input wire addr_two_words_o,
  input wire irq_to_system_o,
  input wire arb_start_o,
  input wire err_flag_o
);
  localparam [3:0] DMA_EFF = (DMA_CHANNELS < 4'h2) ? 4'h2 : DMA_CHANNELS;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // gating, enable and error flag relations
  a_gate_off: assert property (
    !master_enable_o ##1 !master_enable_o |-> !irq_to_system_o && !arb_start_o)
    else $error("gated output while disabled");
  a_me_timeout: assert property (
    bus_timeout_i |=> !master_enable_o) else $error("enable kept after timeout");
  a_me_rise: assert property (
    $rose(master_enable_o) |-> $past(store_i && reg_sel_i == 2'h0 && wdata_i[31], 2))
    else $error("enable set without store");
  a_arb_level: assert property (
    arb_start_o |-> $past(arb_req_i && arb_level_i != 4'hF && !bus_timeout_i))
    else $error("bad arbitration start");
  a_flag_set: assert property (
    bus_timeout_i |=> err_flag_o) else $error("flag not set");
  a_flag_hold: assert property (
    err_flag_o && !err_clear_i |=> err_flag_o) else $error("flag dropped");
  // load port answers
  a_rvalid_load: assert property (
    rvalid_o == $past(load_i)) else $error("rvalid not one cycle after load");
  a_cfg_fixed: assert property (
    $past(load_i && reg_sel_i == 2'h0) |-> rdata_o[30:8] == 23'h0
    && rdata_o[6:0] == {TABLE_MAX, DMA_EFF}) else $error("config fixed fields wrong");
  a_pers_mask: assert property (
    $past(load_i && reg_sel_i == 2'h1) |-> (rdata_o & ~PERS_MASK) == 32'h0)
    else $error("unimplemented bits nonzero");
  a_snap_zero: assert property (
    $past(load_i && reg_sel_i == 2'h2) |-> rdata_o[31:8] == 24'h0
    && ($past(err_flag_o) || rdata_o == 32'h0)) else $error("snapshot read wrong");
  a_two_words: assert property (
    !$past(rst_i) |-> addr_two_words_o == WIDE_CAPABLE[0]) else $error("address size wrong");
  c_lock: cover property (bus_timeout_i && io_cycle_i);
  c_arb: cover property (arb_start_o);
  c_irq: cover property (irq_to_system_o);
  c_clear: cover property (err_flag_o && err_clear_i);
endmodule
bind io_ctrl_config_status_regs io_ctrl_sva #(.WIDE_CAPABLE(WIDE_CAPABLE),
  .TABLE_MAX(TABLE_MAX), .DMA_CHANNELS(DMA_CHANNELS), .PERS_MASK(PERS_MASK)) u_io_ctrl_sva (
  .ref_clk_i, .rst_i, .reg_sel_i, .load_i, .store_i, .wdata_i, .rdata_o, .rvalid_o,
  .bus_timeout_i, .io_cycle_i, .err_clear_i, .ext_irq_i, .arb_req_i, .arb_level_i,
  .master_enable_o, .addr_two_words_o, .irq_to_system_o, .arb_start_o, .err_flag_o);
`default_nettype wire

// ### test/bus_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module bus_side_model (
  input wire ref_clk_i,
  input wire drive_i,
  input wire fault_i,
  input wire [7:0] lines_i,
  output wire [7:0] pins_o,
  output wire bus_timeout_o
);
  logic [7:0] last = 8'h00;
  // remember driven lines; released lines show their inverse
  always @(posedge ref_clk_i) begin
    if (drive_i) begin
      last <= lines_i;
    end
  end
  assign pins_o = drive_i ? lines_i : ~last;
  assign bus_timeout_o = fault_i;
endmodule
`default_nettype wire

// ### test/io_ctrl_config_status_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module io_ctrl_config_status_regs_bench;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] sel = 2'h0;
  logic load = 1'b0, store = 1'b0, fault_req = 1'b0, io_cyc = 1'b0, clr = 1'b0;
  logic irq = 1'b0, areq = 1'b0, drive = 1'b0;
  logic [3:0] alvl = 4'h0;
  logic [7:0] lines = 8'h00;
  logic [31:0] wdata = 32'h0;
  wire [31:0] rdata, pers;
  wire [7:0] pins;
  wire [3:0] arb_lvl, dma;
  wire tmo, rvalid, me, wide, two, irq_o, astart, flag;
  wire [31:0] rdata_n;
  wire [3:0] dma_n;
  wire wide_n, two_n;
  int miscompares = 0;
  int num_checks = 0;
  bus_side_model u_bus_side_model (.ref_clk_i, .drive_i(drive), .fault_i(fault_req),
    .lines_i(lines), .pins_o(pins), .bus_timeout_o(tmo));
  io_ctrl_config_status_regs u_io_ctrl_config_status_regs (.ref_clk_i, .rst_i,
    .reg_sel_i(sel), .load_i(load), .store_i(store), .wdata_i(wdata), .rdata_o(rdata),
    .rvalid_o(rvalid), .bus_timeout_i(tmo), .io_cycle_i(io_cyc), .err_clear_i(clr),
    .arb_pin_i(pins[3:0]), .burst_pin_i(pins[4]), .card_channel_ready_pin_i(pins[5]),
    .sdr0_pin_i(pins[6]), .sdr1_pin_i(pins[7]), .ext_irq_i(irq), .arb_req_i(areq),
    .arb_level_i(alvl), .master_enable_o(me), .wide_entry_mode_o(wide),
    .addr_two_words_o(two), .irq_to_system_o(irq_o), .arb_start_o(astart),
    .arb_level_o(arb_lvl), .err_flag_o(flag), .dma_channels_o(dma), .pers_o(pers));
  // narrow-only build with a channel count below the floor
  io_ctrl_config_status_regs #(.WIDE_CAPABLE(0), .DMA_CHANNELS(4'h1))
    u_io_ctrl_config_status_regs_narrow (.ref_clk_i, .rst_i, .reg_sel_i(sel),
    .load_i(load), .store_i(store), .wdata_i(wdata), .rdata_o(rdata_n), .rvalid_o(),
    .bus_timeout_i(tmo), .io_cycle_i(io_cyc), .err_clear_i(clr), .arb_pin_i(pins[3:0]),
    .burst_pin_i(pins[4]), .card_channel_ready_pin_i(pins[5]), .sdr0_pin_i(pins[6]),
    .sdr1_pin_i(pins[7]), .ext_irq_i(irq), .arb_req_i(areq), .arb_level_i(alvl),
    .master_enable_o(), .wide_entry_mode_o(wide_n), .addr_two_words_o(two_n),
    .irq_to_system_o(), .arb_start_o(), .arb_level_o(), .err_flag_o(),
    .dma_channels_o(dma_n), .pers_o());
  // clock and watchdog
  always #12.5 ref_clk_i = ~ref_clk_i;
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
  task automatic step(input int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ldc(input logic [1:0] s, input logic [31:0] exp);
    sel = s;
    load = 1'b1;
    step();
    load = 1'b0;
    chk(32'(rvalid), 32'h1);
    chk(rdata, exp);
  endtask
  task automatic st(input logic [1:0] s, input logic [31:0] d);
    sel = s;
    wdata = d;
    store = 1'b1;
    step();
    store = 1'b0;
    step();
  endtask
  task automatic fault;
    fault_req = 1'b1;
    step();
    fault_req = 1'b0;
  endtask
  // configuration fields, read-only parts and wide mode
  task automatic t_cfg;
    ldc(2'h0, 32'h0000_00F8);
    chk(rdata_n, 32'h0000_0072);
    st(2'h0, 32'hFFFF_FFFF);
    ldc(2'h0, 32'h8000_00F8);
    chk(rdata_n, 32'h8000_0072);
    st(2'h0, 32'h0000_0000);
    st(2'h3, 32'hFFFF_FFFF);
    ldc(2'h0, 32'h0000_0078);
    chk(32'({wide, two, dma}), 32'h18);
    chk(32'({wide_n, two_n, dma_n}), 32'h02);
    $display("t_cfg done");
  endtask
  task automatic t_pers;
    st(2'h1, 32'hFFFF_FFFF);
    ldc(2'h1, 32'h0000_00FF);
    chk(pers, 32'h0000_00FF);
    $display("t_pers done");
  endtask
  // capture, lock against a second fault, store ignored, rearm
  task automatic t_snap;
    st(2'h0, 32'h8000_0000);
    ldc(2'h2, 32'h0);
    drive = 1'b1;
    lines = 8'hA5;
    io_cyc = 1'b1;
    step(6);
    fault();
    chk(32'({me, flag}), 32'h1);
    ldc(2'h2, 32'h0000_00A5);
    lines = 8'h5A;
    step(6);
    fault();
    st(2'h2, 32'hFFFF_FFFF);
    ldc(2'h2, 32'h0000_00A5);
    drive = 1'b0;
    clr = 1'b1;
    step();
    clr = 1'b0;
    chk(32'(flag), 32'h0);
    ldc(2'h2, 32'h0);
    io_cyc = 1'b0;
    drive = 1'b1;
    lines = 8'h3C;
    step(6);
    fault();
    ldc(2'h2, 32'h0000_003C);
    lines = 8'hC3;
    step(6);
    fault();
    ldc(2'h2, 32'h0000_00C3);
    $display("t_snap done");
  endtask
  // interrupt and arbitration gating
  task automatic t_gate;
    st(2'h0, 32'h8000_0080);
    irq = 1'b1;
    areq = 1'b1;
    alvl = 4'h3;
    step(2);
    chk(32'({irq_o, astart, arb_lvl}), 32'h33);
    alvl = 4'hF;
    step(2);
    chk(32'(astart), 32'h0);
    fault();
    step();
    chk(32'({me, irq_o}), 32'h0);
    $display("t_gate done");
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    step(2);
    rst_i = 1'b0;
    step();
    t_cfg();
    t_pers();
    t_snap();
    t_gate();
    finish_test();
  end
endmodule
`default_nettype wire
